// ### rtl/epirq_flags.sv
`timescale 1ns/100ps
module epirq_flags (
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic [2:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic      [31:0]            o_avs_readdata,
  output logic                        o_avs_waitrequest,
  input  wire logic [2:0]             i_ext_pin,
  input  wire logic                   i_large_variant,
  input  wire logic                   i_mcu_mode,
  input  wire logic                   i_psp_access,
  input  wire logic                   i_adc_done,
  input  wire logic                   i_rx_buffer_full,
  input  wire logic                   i_rx_buffer_read,
  input  wire logic                   i_tx_buffer_empty,
  input  wire logic                   i_tx_buffer_write,
  input  wire logic                   i_sync_done,
  input  wire epirq_pkg::epirq_ccmode_e i_cc_mode,
  input  wire logic                   i_cc_capture,
  input  wire logic                   i_cc_compare,
  input  wire logic                   i_timer2_match,
  input  wire logic                   i_timer1_overflow,
  output logic                        o_irq_high,
  output logic                        o_irq_low,
  output logic                        o_irq
);
  import epirq_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrl3;
    logic [7:0]  flags1;
    logic        global_irq_enable;
    logic [2:0]  edge_sel;
    logic [7:0]  penable;
    logic [7:0]  pprio;
    logic        ext3_priority;
    logic [7:0]  estat;
    logic [7:0]  emask;
    logic [2:0]  pin_q;
    logic        rx_q;
    logic        tx_q;
    logic        ack;
    logic [31:0] rdata;
  } epirq_state_s;

  epirq_state_s st_q;
  epirq_state_s st_d;

  // Byte-lane-gated write strobe; only lane 0 carries register data.
  function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] target,
                                  input logic we, input logic be0);
    wr_hit = we && be0 && (a == target);
  endfunction

  // Write-one-to-clear with set priority over the clear.
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
                                     input logic [7:0] set);
    w1c = (cur & ~clr) | set;
  endfunction

  logic        access;
  logic        ctrl3_wr;
  logic        flags1_wr;
  logic [2:0]  ext_event;
  logic [7:0]  periph_set;
  logic [7:0]  new_flags1;
  logic [7:0]  new_ctrl3;
  logic [10:0] pend_hi;
  logic [10:0] pend_lo;
  logic [10:0] srcs;
  logic [10:0] ens;
  logic [10:0] prios;
  logic [7:0]  ev_set;
  logic [7:0]  wd;

  // One wait state: the request is answered on the second edge it is held.
  assign access            = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = access & ~st_q.ack;
  assign o_avs_readdata    = st_q.rdata;
  assign wd                = i_avs_writedata[7:0];

  always_comb begin
    st_d = st_q;
    st_d.ack = access & ~st_q.ack;
    ctrl3_wr  = wr_hit(i_avs_address, ADDR_CTRL3, i_avs_write & st_q.ack,
                       i_avs_byteenable[0]);
    flags1_wr = wr_hit(i_avs_address, ADDR_FLAGS1, i_avs_write & st_q.ack,
                       i_avs_byteenable[0]);

    // Edge detect on the synchronous pins, polarity per select bit.
    st_d.pin_q = i_ext_pin;
    for (int i = 0; i < 3; i++) begin
      ext_event[i] = st_q.edge_sel[i] ? (i_ext_pin[i] & ~st_q.pin_q[i])
                                      : (~i_ext_pin[i] & st_q.pin_q[i]);
    end

    // Peripheral set terms; none looks at any enable bit.
    periph_set = 8'h00;
    periph_set[FLAGS1_PARALLEL] = i_psp_access & (~i_large_variant | i_mcu_mode);
    periph_set[FLAGS1_ADC]      = i_adc_done;
    periph_set[FLAGS1_SYNC]     = i_sync_done;
    periph_set[FLAGS1_CAPCOMP]  = (i_cc_mode == EPIRQ_CC_CAPTURE && i_cc_capture) ||
                                  (i_cc_mode == EPIRQ_CC_COMPARE && i_cc_compare);
    periph_set[FLAGS1_TIMER2]   = i_timer2_match;
    periph_set[FLAGS1_TIMER1]   = i_timer1_overflow;

    // Software writes zero to clear; a coincident event still sets.
    new_flags1 = st_q.flags1;
    if (flags1_wr) begin
      new_flags1 = (st_q.flags1 & (wd | ~FLAGS1_SW_MASK));
    end
    new_flags1 = new_flags1 | (periph_set & FLAGS1_SW_MASK);
    // Serial flags track buffer state; a read or write drops them at once.
    new_flags1[FLAGS1_RX] = i_rx_buffer_full & ~i_rx_buffer_read;
    new_flags1[FLAGS1_TX] = i_tx_buffer_empty & ~i_tx_buffer_write;
    st_d.flags1 = new_flags1;

    new_ctrl3 = st_q.ctrl3;
    if (ctrl3_wr) begin
      new_ctrl3[7:6] = wd[7:6];
      new_ctrl3[5:3] = wd[5:3];
      new_ctrl3[2:0] = st_q.ctrl3[2:0] & wd[2:0];
    end
    new_ctrl3[2:0] = new_ctrl3[2:0] | ext_event;
    st_d.ctrl3 = new_ctrl3;

    // Registers of the wider unit that this block needs to route requests.
    if (wr_hit(i_avs_address, ADDR_GLOBAL, i_avs_write & st_q.ack, i_avs_byteenable[0])) begin
      st_d.global_irq_enable = wd[0];
      st_d.ext3_priority     = wd[1];
    end
    if (wr_hit(i_avs_address, ADDR_EDGE, i_avs_write & st_q.ack, i_avs_byteenable[0])) begin
      st_d.edge_sel = wd[2:0];
    end
    if (wr_hit(i_avs_address, ADDR_PENABLE, i_avs_write & st_q.ack, i_avs_byteenable[0])) begin
      st_d.penable = wd;
    end
    if (wr_hit(i_avs_address, ADDR_PPRIO, i_avs_write & st_q.ack, i_avs_byteenable[0])) begin
      st_d.pprio = wd;
    end
    if (wr_hit(i_avs_address, ADDR_EMASK, i_avs_write & st_q.ack, i_avs_byteenable[0])) begin
      st_d.emask = wd;
    end

    // Request routing over all eleven sources.
    srcs  = {st_q.flags1, st_q.ctrl3[2:0]};
    ens   = {st_q.penable, st_q.ctrl3[5:3]};
    prios = {st_q.pprio, st_q.ext3_priority, st_q.ctrl3[7], st_q.ctrl3[6]};
    pend_hi = srcs & ens & prios & {11{st_q.global_irq_enable}};
    pend_lo = srcs & ens & ~prios & {11{st_q.global_irq_enable}};

    // Event status: bit 0 high request rose, bit 1 low request rose.
    ev_set = {6'h00, (|pend_lo) & ~st_q.rx_q, (|pend_hi) & ~st_q.tx_q};
    st_d.rx_q = |pend_lo;
    st_d.tx_q = |pend_hi;
    if (wr_hit(i_avs_address, ADDR_ESTAT, i_avs_write & st_q.ack, i_avs_byteenable[0])) begin
      st_d.estat = w1c(st_q.estat, wd, ev_set);
    end else begin
      st_d.estat = st_q.estat | ev_set;
    end

    // Read data captured on the wait-state edge, before the answering edge.
    if (i_avs_read && !st_q.ack) begin
      case (i_avs_address)
        ADDR_CTRL3:   st_d.rdata = {24'h000000, st_q.ctrl3};
        ADDR_FLAGS1:  st_d.rdata = {24'h000000, st_q.flags1};
        ADDR_GLOBAL:  st_d.rdata = {30'h00000000, st_q.ext3_priority, st_q.global_irq_enable};
        ADDR_EDGE:    st_d.rdata = {29'h00000000, st_q.edge_sel};
        ADDR_PENABLE: st_d.rdata = {24'h000000, st_q.penable};
        ADDR_PPRIO:   st_d.rdata = {24'h000000, st_q.pprio};
        ADDR_ESTAT:   st_d.rdata = {24'h000000, st_q.estat};
        ADDR_EMASK:   st_d.rdata = {24'h000000, st_q.emask};
        default:      st_d.rdata = 32'h00000000;
      endcase
    end
  end

  // All state updates on every edge; reset loads constants only.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '{ctrl3: CTRL3_RESET, flags1: FLAGS1_RESET, global_irq_enable: 1'b0,
                edge_sel: EDGE_RESET, penable: 8'h00, pprio: PPRIO_RESET,
                ext3_priority: EXT3_PRIO_RESET[0], estat: 8'h00, emask: 8'h00,
                pin_q: 3'h0, rx_q: 1'b0, tx_q: 1'b0, ack: 1'b0, rdata: 32'h00000000};
    end else begin
      st_q <= st_d;
    end
  end

  // Core request lines are level outputs from the flag registers.
  assign o_irq_high = st_q.tx_q;
  assign o_irq_low  = st_q.rx_q;
  assign o_irq      = |(st_q.estat & st_q.emask);

endmodule // epirq_flags

// ### rtl/epirq_pkg.sv
package epirq_pkg;

  // Register word addresses on the Avalon-MM slave (word index).
  localparam logic [2:0] ADDR_CTRL3   = 3'h0;
  localparam logic [2:0] ADDR_FLAGS1  = 3'h1;
  localparam logic [2:0] ADDR_GLOBAL  = 3'h2;
  localparam logic [2:0] ADDR_EDGE    = 3'h3;
  localparam logic [2:0] ADDR_PENABLE = 3'h4;
  localparam logic [2:0] ADDR_PPRIO   = 3'h5;
  localparam logic [2:0] ADDR_ESTAT   = 3'h6;
  localparam logic [2:0] ADDR_EMASK   = 3'h7;

  // Field positions in the third control register.
  localparam int CTRL3_EXT2_PRIO = 7;
  localparam int CTRL3_EXT1_PRIO = 6;
  localparam int CTRL3_EN_LSB    = 3;
  localparam int CTRL3_FLAG_LSB  = 0;

  // Field positions in the first peripheral flag register.
  localparam int FLAGS1_PARALLEL = 7;
  localparam int FLAGS1_ADC      = 6;
  localparam int FLAGS1_RX       = 5;
  localparam int FLAGS1_TX       = 4;
  localparam int FLAGS1_SYNC     = 3;
  localparam int FLAGS1_CAPCOMP  = 2;
  localparam int FLAGS1_TIMER2   = 1;
  localparam int FLAGS1_TIMER1   = 0;

  // Bits of the edge select register: ext1 at 0, ext2 at 1, ext3 at 2.
  localparam logic [7:0] CTRL3_RESET  = 8'hc0;
  localparam logic [7:0] FLAGS1_RESET = 8'h00;
  localparam logic [2:0] EDGE_RESET   = 3'h7;
  localparam logic [7:0] PPRIO_RESET  = 8'hff;
  localparam logic [7:0] EXT3_PRIO_RESET = 8'h01;

  // Flags that software may clear; the two serial flags follow the buffers.
  localparam logic [7:0] FLAGS1_SW_MASK = 8'hcf;

  // Capture/compare unit modes.
  typedef enum logic [1:0] {
    EPIRQ_CC_OFF,
    EPIRQ_CC_CAPTURE,
    EPIRQ_CC_COMPARE,
    EPIRQ_CC_PWM
  } epirq_ccmode_e;

endpackage

// ### bench/epirq_flags_props.sv
`timescale 1ns/100ps
// Sees only top ports; request outputs may fall only after writes or buffer traffic.
module epirq_flags_props (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_rx_buffer_full,
  input wire logic        i_rx_buffer_read,
  input wire logic        i_tx_buffer_empty,
  input wire logic        i_tx_buffer_write,
  input wire logic        o_irq_high,
  input wire logic        o_irq_low,
  input wire logic        o_irq
);
  logic [4:0] hist_q;
  logic       rx_q, tx_q, act, req;
  // Five cycles of history cover the write-to-flag-to-request path.
  assign act = i_avs_write | i_rx_buffer_read | i_tx_buffer_write
             | (i_rx_buffer_full ^ rx_q) | (i_tx_buffer_empty ^ tx_q);
  assign req = i_avs_read | i_avs_write;
  // Keeps recent activity that could legally clear a flag.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) {hist_q, rx_q, tx_q} <= '0;
    else {hist_q, rx_q, tx_q} <= {hist_q[3:0], act, i_rx_buffer_full, i_tx_buffer_empty};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_wait; req && o_avs_waitrequest; endsequence
  sequence s_answer; req && !o_avs_waitrequest; endsequence
  chk_bus_cycle: assert property ($rose(req) |-> s_wait ##1 s_answer)
    else $error("bus cycle lacks one wait state");
  chk_wait_answer: assert property (s_wait |=> !o_avs_waitrequest)
    else $error("bus wait too long");
  chk_upper_zero: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_read_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved");
  chk_quiet_reset: assert property ($rose(i_arst_n) |-> !(o_irq_high || o_irq_low || o_irq))
    else $error("request out of reset");
  chk_high_sticky: assert property ($fell(o_irq_high) |-> |hist_q)
    else $error("high request fell alone");
  chk_low_sticky: assert property ($fell(o_irq_low) |-> |hist_q)
    else $error("low request fell alone");
  chk_status_sticky: assert property ($fell(o_irq) |-> |hist_q)
    else $error("status interrupt fell alone");
endmodule // epirq_flags_props
bind epirq_flags epirq_flags_props epirq_flags_props_inst (.i_clk, .i_arst_n, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_rx_buffer_full, .i_rx_buffer_read,
  .i_tx_buffer_empty, .i_tx_buffer_write, .o_irq_high, .o_irq_low, .o_irq);

// ### bench/epirq_src.sv
`timescale 1ns/100ps
// Event sources and core buffer accesses; command bits 0 to 8 each give a one-cycle pulse, bits 9 and 10 set buffer levels.
module epirq_src (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [10:0] i_fire,
  output logic      [8:0]  o_pulse,
  output logic             o_rx_full,
  output logic             o_tx_empty
);
  // Bits 9 and 10 fill and drain the buffers; bits 7 and 8 read and write them.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pulse    <= '0;
      o_rx_full  <= 1'b0;
      o_tx_empty <= 1'b1;
    end else begin
      o_pulse    <= i_fire[8:0];
      o_rx_full  <= i_fire[9] | (o_rx_full & ~i_fire[7]);
      o_tx_empty <= i_fire[10] | (o_tx_empty & ~i_fire[8]);
    end
  end
endmodule // epirq_src

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
  import epirq_pkg::*;
  logic          i_clk = 1'b0, i_arst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic          i_large_variant = 1'b1, i_mcu_mode = 1'b1, rx_full, tx_empty;
  logic          o_irq_high, o_irq_low, o_irq, o_avs_waitrequest;
  logic [2:0]    i_avs_address = '0, i_ext_pin = '0;
  logic [3:0]    i_avs_byteenable = 4'h1;
  logic [31:0]   i_avs_writedata = '0, o_avs_readdata, junk;
  logic [10:0]   fire = '0;
  logic [8:0]    pl;
  logic [7:0]    rst_v [8] = '{8'hc0, 8'h10, 8'h02, 8'h07, 8'h00, 8'hff, 8'h00, 8'h00};
  epirq_ccmode_e i_cc_mode = EPIRQ_CC_CAPTURE;
  int            n_fail = 0, checks = 0, cyc = 0;
  epirq_src epirq_src_inst (.i_clk, .i_arst_n, .i_fire(fire), .o_pulse(pl),
    .o_rx_full(rx_full), .o_tx_empty(tx_empty));
  epirq_flags epirq_flags_inst (.i_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_ext_pin,
    .i_large_variant, .i_mcu_mode, .i_psp_access(pl[0]), .i_adc_done(pl[1]),
    .i_rx_buffer_full(rx_full), .i_rx_buffer_read(pl[7]), .i_tx_buffer_empty(tx_empty),
    .i_tx_buffer_write(pl[8]), .i_sync_done(pl[2]), .i_cc_mode, .i_cc_capture(pl[3]),
    .i_cc_compare(pl[4]), .i_timer2_match(pl[5]), .i_timer1_overflow(pl[6]), .o_irq_high,
    .o_irq_low, .o_irq);
  initial forever #2 i_clk = ~i_clk;
  // A hung handshake ends the run; the tests need well under this many cycles.
  always @(posedge i_clk) if (++cyc == 5000) begin
    n_fail++;
    summarize();
  end
  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus cycle; the request holds until waitrequest is sampled low, then an idle edge.
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] v,
                     output logic [31:0] d);
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, v};
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    d = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    acc(1'b1, a, v, junk);
  endtask
  task automatic rd(input string n, input logic [2:0] a, input logic [7:0] e);
    logic [31:0] d;
    acc(1'b0, a, 8'h0, d);
    cmp(n, {24'h0, e}, d);
  endtask
  // Two edges after the pulse the flag is visible.
  task automatic pulse(input logic [10:0] m);
    fire <= m;
    @(posedge i_clk);
    fire <= '0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic irqs(input logic [2:0] e);
    repeat (3) @(posedge i_clk);
    cmp("irq high/low/status", {29'h0, e}, {29'h0, o_irq_high, o_irq_low, o_irq});
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 8; a++) rd("reset value", 3'(a), rst_v[a]);
    $display("test reset done");
    // Sticky sources set with every enable off; writing zero clears all but the buffer flags.
    pulse(11'h06f);
    rd("flags1 set", ADDR_FLAGS1, 8'hdf);
    wr(ADDR_FLAGS1, 8'h00);
    rd("flags1 clear", ADDR_FLAGS1, 8'h10);
    i_mcu_mode <= 1'b0;
    pulse(11'h001);
    rd("parallel off", ADDR_FLAGS1, 8'h10);
    i_large_variant <= 1'b0;
    pulse(11'h001);
    rd("parallel small", ADDR_FLAGS1, 8'h90);
    wr(ADDR_FLAGS1, 8'h00);
    for (int m = 0; m < 4; m++) for (int k = 0; k < 2; k++) begin
      i_cc_mode <= epirq_ccmode_e'(m);
      pulse(11'h008 << k);
      rd("capcomp", ADDR_FLAGS1, (m == k + 1) ? 8'h14 : 8'h10);
      wr(ADDR_FLAGS1, 8'h00);
    end
    pulse(11'h200);
    wr(ADDR_FLAGS1, 8'h00);
    rd("rx full", ADDR_FLAGS1, 8'h30);
    pulse(11'h080);
    rd("rx read", ADDR_FLAGS1, 8'h10);
    pulse(11'h100);
    rd("tx write", ADDR_FLAGS1, 8'h00);
    pulse(11'h400);
    // The converter pulse lands on the edge that takes the clearing write.
    fork
      wr(ADDR_FLAGS1, 8'h00);
      pulse(11'h002);
    join
    rd("set beats clear", ADDR_FLAGS1, 8'h50);
    $display("test peripheral done");
    wr(ADDR_GLOBAL, 8'h01);
    wr(ADDR_CTRL3, 8'hc0);
    wr(ADDR_CTRL3, 8'hc8);
    irqs(3'b000);
    i_ext_pin <= 3'b111;
    irqs(3'b100);
    rd("ctrl3 flags", ADDR_CTRL3, 8'hcf);
    wr(ADDR_EMASK, 8'h01);
    irqs(3'b101);
    wr(ADDR_ESTAT, 8'h01);
    irqs(3'b100);
    wr(ADDR_EDGE, 8'h00);
    wr(ADDR_CTRL3, 8'h88);
    irqs(3'b000);
    i_ext_pin <= 3'b110;
    irqs(3'b010);
    wr(ADDR_CTRL3, 8'h88);
    i_ext_pin <= 3'b111;
    irqs(3'b000);
    i_ext_pin <= 3'b110;
    irqs(3'b010);
    // The converter flag is still set; enabling it routes it by its priority bit.
    wr(ADDR_PENABLE, 8'h40);
    irqs(3'b111);
    wr(ADDR_PPRIO, 8'hbf);
    irqs(3'b011);
    wr(ADDR_GLOBAL, 8'h00);
    irqs(3'b001);
    $display("test external done");
    summarize();
  end
endmodule // tb
